// ===== eid_ahb_master.sv
// ahb-lite master model issuing single word transfers
`timescale 1ns/1ps
module eid_ahb_master (
	input wire logic clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o = 1'b0,
	output logic [31:0] haddr_o = 32'h0000_0000,
	output logic [1:0] htrans_o = 2'b00,
	output logic hwrite_o = 1'b0,
	output logic [2:0] hsize_o = 3'h2,
	output logic [31:0] hwdata_o = 32'h0000_0000
);
	// called right after a rising edge; returns at the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic to);
		int n;
		n = 0;
		hsel_o <= 1'b1;
		htrans_o <= 2'b10;
		haddr_o <= a;
		hwrite_o <= wr;
		hsize_o <= 3'h2;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 50);
		htrans_o <= 2'b00;
		hwdata_o <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 100);
		r = hrdata_i;
		// released write data never keeps showing the last value
		hwdata_o <= ~d;
		to = (n >= 100);
	endtask : xfer
endmodule : eid_ahb_master

// ===== eid_cfg.svh
// constants for the enhanced instruction decoder
`ifndef EID_CFG_SVH
`define EID_CFG_SVH
`define EID_INSN_W 14
`define EID_Q_PER_CYCLE 4
`define EID_CLK_MHZ 20
`define EID_FILE_W 7
`define EID_BIT_LO 7
`define EID_DEST_BIT 7
`define EID_LIT8_W 8
`define EID_LIT11_W 11
`define EID_LIT9_W 9
`define EID_LIT7_W 7
`define EID_LIT5_W 5
`define EID_LIT6_W 6
`define EID_STATUS_C 0
`define EID_STATUS_DC 1
`define EID_STATUS_Z 2
`define EID_STATUS_PD 3
`define EID_STATUS_TO 4
`define EID_ADDR_CTRL 32'h0000_0000
`define EID_ADDR_INSN 32'h0000_0004
`define EID_ADDR_DEC 32'h0000_0008
`define EID_ADDR_STAT 32'h0000_000C
`define EID_ADDR_FLAGS 32'h0000_0010
`endif

// ===== eid_decoder.sv
// instruction decoder with cycle-count control behind an ahb-lite slave
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "eid_cfg.svh"
// What this block does
// - takes 14-bit words holding opcode and all operands, no extension words
// - each instruction cycle spans four oscillator clocks
// - calls, returns, direct, relative and accumulator branches take two cycles
// - indirect window access with pointer top bit set adds one cycle
// - file register instructions other than the bit tests read, modify, then write
// - destination bit 0 writes accumulator, 1 writes the file register
// - byte words: file address bits 6:0, destination bit 7
// - bit words: bit index 9:7, file 6:0, four bit operations
// - general literal words: 8-bit immediate 7:0, opcode 13:8
// - call and direct branch carry an 11-bit target in 10:0
// - bank load uses 5-bit literal, pc high latch load 7-bit
// - relative branch takes signed 9-bit immediate, two cycles
// - pointer offset words: select bit and 6-bit immediate
// - pointer mode words: select bit and 2-bit pre/post mode
// - byte operations decode from bits 13:8
// - shifts update carry and zero, rotates update carry only
// - literal add/sub update c, dc, z; logic literals update z
// - skips take two cycles when the test is true, second is nop
// - control words branch/call by accumulator, returns, return with literal
// - inherent words; watchdog clear sets timeout and powerdown flags, sleep sets timeout and clears powerdown
// - clearing file or accumulator sets zero, low bits don't care
module eid_decoder
	import eid_pkg::*;
#(
	parameter int Q_PER_CYCLE = `EID_Q_PER_CYCLE
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic busy_o
);
	// software-visible state
	logic [13:0] insn_q;
	logic [7:0] acc_q;
	logic [7:0] file_q;
	logic ptr_top_q;
	logic test_true_q;
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	logic [7:0] acc_d;
	logic [7:0] file_d;
	logic go_q;
	logic busy_q;
	logic [1:0] cycles_q;
	logic [1:0] cycles_left_q;
	logic [1:0] qclk_q;
	logic [7:0] result_q;
	logic res_to_acc_q;
	logic file_rd_q;
	logic file_wr_q;
	logic [31:0] hrdata_q;
	eid_state_type state_q;
	// bus address phase capture
	logic ap_valid_q;
	logic ap_write_q;
	logic [4:0] ap_addr_q;
	wire logic ap_take = hsel_i & htrans_i[1] & hready_i;
	// only the low word block is mapped; anything above it aliases nothing
	wire logic ap_map = (haddr_i[31:5] == 27'h0000000);
	wire logic [4:0] rd_addr = haddr_i[4:0];
	// decode
	wire logic [5:0] hi6 = insn_q[13:8];
	wire logic [6:0] fadr = insn_q[`EID_FILE_W-1:0];
	wire logic dest = insn_q[`EID_DEST_BIT];
	wire logic [2:0] bidx = insn_q[9:`EID_BIT_LO];
	wire logic [7:0] lit8 = insn_q[`EID_LIT8_W-1:0];
	wire logic [10:0] lit11 = insn_q[`EID_LIT11_W-1:0];
	wire logic [8:0] lit9 = insn_q[`EID_LIT9_W-1:0];
	wire logic [6:0] lit7 = insn_q[`EID_LIT7_W-1:0];
	wire logic [4:0] lit5 = insn_q[`EID_LIT5_W-1:0];
	wire logic [5:0] lit6 = insn_q[`EID_LIT6_W-1:0];
	wire logic ptr_sel = insn_q[6] & insn_q[13] | insn_q[2] & ~insn_q[13];
	wire logic [1:0] pmode = insn_q[1:0];
	eid_op_type op;
	always_comb begin
		op = EID_OP_NOP;
		unique casez (insn_q)
			14'b00_0111_????_????: op = EID_OP_ADD_ACC_FILE;
			14'b11_1101_????_????: op = EID_OP_ADD_ACC_FILE_CARRY;
			14'b00_0101_????_????: op = EID_OP_AND_ACC_FILE;
			14'b11_0111_????_????: op = EID_OP_ASR;
			14'b11_0101_????_????: op = EID_OP_LSL;
			14'b11_0110_????_????: op = EID_OP_LSR;
			14'b00_0001_1???_????: op = EID_OP_CLEAR_FILE;
			14'b00_0001_0000_00??: op = EID_OP_CLEAR_ACC;
			14'b00_1001_????_????: op = EID_OP_COMF;
			14'b00_0011_????_????: op = EID_OP_DECREMENT_FILE;
			14'b00_1010_????_????: op = EID_OP_INCREMENT_FILE;
			14'b00_0100_????_????: op = EID_OP_IORWF;
			14'b00_1000_????_????: op = EID_OP_MOVE_FILE;
			14'b00_0000_1???_????: op = EID_OP_MOVWF;
			14'b00_1101_????_????: op = EID_OP_RLC;
			14'b00_1100_????_????: op = EID_OP_RRC;
			14'b00_0010_????_????: op = EID_OP_SUBWF;
			14'b11_1011_????_????: op = EID_OP_SUB_ACC_FILE_BORROW;
			14'b00_1110_????_????: op = EID_OP_SWAP;
			14'b00_0110_????_????: op = EID_OP_XORWF;
			14'b00_1011_????_????: op = EID_OP_DECSZ;
			14'b00_1111_????_????: op = EID_OP_INCSZ;
			14'b01_00??_????_????: op = EID_OP_BCLR;
			14'b01_01??_????_????: op = EID_OP_BSET;
			14'b01_10??_????_????: op = EID_OP_BTSC;
			14'b01_11??_????_????: op = EID_OP_BTSS;
			14'b11_1110_????_????: op = EID_OP_ADDLIT;
			14'b11_1001_????_????: op = EID_OP_ANDLIT;
			14'b11_1000_????_????: op = EID_OP_ORLIT;
			14'b00_0000_001?_????: op = EID_OP_LDBANK;
			14'b11_0001_1???_????: op = EID_OP_LDPCH;
			14'b11_0000_????_????: op = EID_OP_MOVLIT;
			14'b11_1100_????_????: op = EID_OP_SUBLIT;
			14'b11_1010_????_????: op = EID_OP_XORLIT;
			14'b11_001?_????_????: op = EID_OP_RELBR;
			14'b00_0000_0000_1011: op = EID_OP_BRACC;
			14'b10_0???_????_????: op = EID_OP_CALL;
			14'b00_0000_0000_1010: op = EID_OP_CALLACC;
			14'b10_1???_????_????: op = EID_OP_DIRECT_BRANCH;
			14'b00_0000_0000_1001: op = EID_OP_RETIRQ;
			14'b11_0100_????_????: op = EID_OP_RETLIT;
			14'b00_0000_0000_1000: op = EID_OP_RETURN;
			14'b00_0000_0110_0100: op = EID_OP_WDTCLR;
			14'b00_0000_0110_0010: op = EID_OP_OPTION;
			14'b00_0000_0000_0001: op = EID_OP_SWRESET;
			14'b00_0000_0110_0011: op = EID_OP_SLEEP;
			14'b00_0000_0110_0101,
			14'b00_0000_0110_0110,
			14'b00_0000_0110_0111: op = EID_OP_TRISTATE_LOAD_OP;
			14'b11_0001_0???_????: op = EID_OP_PTRADD;
			14'b00_0000_0001_0???: op = EID_OP_IRDMODE;
			14'b11_1111_0???_????: op = EID_OP_IRDIDX;
			14'b00_0000_0001_1???: op = EID_OP_IWRMODE;
			14'b11_1111_1???_????: op = EID_OP_IWRIDX;
			default: op = EID_OP_NOP;
		endcase
	end
	// classification
	wire logic two_cyc = (op == EID_OP_CALL) | (op == EID_OP_CALLACC) | (op == EID_OP_RETIRQ)
		| (op == EID_OP_RETLIT) | (op == EID_OP_RETURN) | (op == EID_OP_DIRECT_BRANCH)
		| (op == EID_OP_RELBR) | (op == EID_OP_BRACC);
	wire logic file_op = (op >= EID_OP_ADD_ACC_FILE && op <= EID_OP_BTSS && op != EID_OP_CLEAR_ACC);
	wire logic indirect_op = (op == EID_OP_IRDMODE) | (op == EID_OP_IRDIDX)
		| (op == EID_OP_IWRMODE) | (op == EID_OP_IWRIDX);
	wire logic hits_window = indirect_op | (file_op & (fadr == 7'h00 || fadr == 7'h01));
	wire logic extra_cyc = hits_window & ptr_top_q;
	wire logic bitval = file_q[bidx];
	// alu
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] res;
	logic res_c;
	logic upd_c;
	logic upd_dc;
	logic upd_z;
	logic to_acc;
	logic wr_file;
	logic skip;
	wire logic cin = flags_q[`EID_STATUS_C];
	always_comb begin
		sum9 = 9'h000;
		sum5 = 5'h00;
		res = 8'h00;
		res_c = cin;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		to_acc = 1'b0;
		wr_file = 1'b0;
		skip = 1'b0;
		unique case (op)
			EID_OP_ADD_ACC_FILE, EID_OP_ADD_ACC_FILE_CARRY: begin
				sum9 = {1'b0, file_q} + {1'b0, acc_q} + {8'h00, (op == EID_OP_ADD_ACC_FILE_CARRY) & cin};
				sum5 = {1'b0, file_q[3:0]} + {1'b0, acc_q[3:0]} + {4'h0, (op == EID_OP_ADD_ACC_FILE_CARRY) & cin};
				res = sum9[7:0];
				res_c = sum9[8];
				{upd_c, upd_dc, upd_z} = 3'b111;
			end
			EID_OP_SUBWF, EID_OP_SUB_ACC_FILE_BORROW: begin
				sum9 = {1'b0, file_q} + {1'b0, ~acc_q} + {8'h00, (op == EID_OP_SUBWF) | cin};
				sum5 = {1'b0, file_q[3:0]} + {1'b0, ~acc_q[3:0]} + {4'h0, (op == EID_OP_SUBWF) | cin};
				res = sum9[7:0];
				res_c = sum9[8];
				{upd_c, upd_dc, upd_z} = 3'b111;
			end
			EID_OP_AND_ACC_FILE: begin res = file_q & acc_q; upd_z = 1'b1; end
			EID_OP_IORWF: begin res = file_q | acc_q; upd_z = 1'b1; end
			EID_OP_XORWF: begin res = file_q ^ acc_q; upd_z = 1'b1; end
			EID_OP_COMF: begin res = ~file_q; upd_z = 1'b1; end
			EID_OP_DECREMENT_FILE: begin res = file_q - 8'h01; upd_z = 1'b1; end
			EID_OP_INCREMENT_FILE: begin res = file_q + 8'h01; upd_z = 1'b1; end
			EID_OP_MOVE_FILE: begin res = file_q; upd_z = 1'b1; end
			EID_OP_ASR: begin res = {file_q[7], file_q[7:1]}; res_c = file_q[0]; {upd_c, upd_z} = 2'b11; end
			EID_OP_LSL: begin res = {file_q[6:0], 1'b0}; res_c = file_q[7]; {upd_c, upd_z} = 2'b11; end
			EID_OP_LSR: begin res = {1'b0, file_q[7:1]}; res_c = file_q[0]; {upd_c, upd_z} = 2'b11; end
			EID_OP_RLC: begin res = {file_q[6:0], cin}; res_c = file_q[7]; upd_c = 1'b1; end
			EID_OP_RRC: begin res = {cin, file_q[7:1]}; res_c = file_q[0]; upd_c = 1'b1; end
			EID_OP_SWAP: res = {file_q[3:0], file_q[7:4]};
			EID_OP_DECSZ: begin res = file_q - 8'h01; skip = (res == 8'h00); end
			EID_OP_INCSZ: begin res = file_q + 8'h01; skip = (res == 8'h00); end
			EID_OP_CLEAR_FILE, EID_OP_CLEAR_ACC: begin res = 8'h00; upd_z = 1'b1; end
			EID_OP_MOVWF: res = acc_q;
			EID_OP_BCLR: res = file_q & ~(8'h01 << bidx);
			EID_OP_BSET: res = file_q | (8'h01 << bidx);
			EID_OP_BTSC: begin res = file_q; skip = ~bitval; end
			EID_OP_BTSS: begin res = file_q; skip = bitval; end
			EID_OP_ADDLIT, EID_OP_SUBLIT: begin
				sum9 = (op == EID_OP_ADDLIT) ? {1'b0, lit8} + {1'b0, acc_q} : {1'b0, lit8} + {1'b0, ~acc_q} + 9'h001;
				sum5 = (op == EID_OP_ADDLIT) ? {1'b0, lit8[3:0]} + {1'b0, acc_q[3:0]}
					: {1'b0, lit8[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
				res = sum9[7:0];
				res_c = sum9[8];
				{upd_c, upd_dc, upd_z} = 3'b111;
			end
			EID_OP_ANDLIT: begin res = lit8 & acc_q; upd_z = 1'b1; end
			EID_OP_ORLIT: begin res = lit8 | acc_q; upd_z = 1'b1; end
			EID_OP_XORLIT: begin res = lit8 ^ acc_q; upd_z = 1'b1; end
			EID_OP_MOVLIT, EID_OP_RETLIT: res = lit8;
			EID_OP_LDBANK: res = {3'b000, lit5};
			EID_OP_LDPCH: res = {1'b0, lit7};
			EID_OP_IRDMODE, EID_OP_IRDIDX: begin res = file_q; upd_z = 1'b1; end
			EID_OP_IWRMODE, EID_OP_IWRIDX: res = acc_q;
			default: res = 8'h00;
		endcase
		// destination steering; writes-only ops still read first
		unique case (op)
			EID_OP_CLEAR_FILE, EID_OP_MOVWF, EID_OP_BCLR, EID_OP_BSET: wr_file = 1'b1;
			EID_OP_BTSC, EID_OP_BTSS, EID_OP_CLEAR_ACC: wr_file = 1'b0;
			default: wr_file = file_op & dest;
		endcase
		to_acc = (file_op & ~dest & ~wr_file & op != EID_OP_BTSC & op != EID_OP_BTSS) | (op == EID_OP_CLEAR_ACC)
			| (op >= EID_OP_ADDLIT && op <= EID_OP_XORLIT && op != EID_OP_LDBANK && op != EID_OP_LDPCH)
			| (op == EID_OP_RETLIT) | (op == EID_OP_IRDMODE) | (op == EID_OP_IRDIDX);
	end
	always_comb begin
		flags_d = flags_q;
		if (upd_c) flags_d[`EID_STATUS_C] = res_c;
		if (upd_dc) flags_d[`EID_STATUS_DC] = sum5[4];
		if (upd_z) flags_d[`EID_STATUS_Z] = (res == 8'h00);
		if (op == EID_OP_WDTCLR) flags_d[`EID_STATUS_TO +: 1] = 1'b1;
		if (op == EID_OP_WDTCLR) flags_d[`EID_STATUS_PD] = 1'b1;
		if (op == EID_OP_SLEEP) flags_d[`EID_STATUS_TO] = 1'b1;
		if (op == EID_OP_SLEEP) flags_d[`EID_STATUS_PD] = 1'b0;
		acc_d = to_acc ? res : acc_q;
		file_d = wr_file ? res : file_q;
	end
	wire logic [1:0] n_cycles = 2'd1 + {1'b0, two_cyc | skip} + {1'b0, extra_cyc};
	// bus register decode
	wire logic wr_ctrl = ap_valid_q & ap_write_q & (ap_addr_q == 5'(`EID_ADDR_CTRL));
	wire logic wr_insn = ap_valid_q & ap_write_q & (ap_addr_q == 5'(`EID_ADDR_INSN));
	wire logic wr_flags = ap_valid_q & ap_write_q & (ap_addr_q == 5'(`EID_ADDR_FLAGS));
	wire logic [31:0] rd_mux =
		(rd_addr == 5'(`EID_ADDR_CTRL)) ? {23'h0, ptr_top_q, acc_q} :
		(rd_addr == 5'(`EID_ADDR_INSN)) ? {18'h0, insn_q} :
		(rd_addr == 5'(`EID_ADDR_DEC)) ? {8'h0, 2'b00, op, res_to_acc_q, file_wr_q, file_rd_q, 5'h00, result_q} :
		(rd_addr == 5'(`EID_ADDR_STAT)) ? {27'h0, cycles_q, busy_q, 2'b00} :
		(rd_addr == 5'(`EID_ADDR_FLAGS)) ? {16'h0, file_q, 3'b000, flags_q} : 32'h0;
	wire logic quarter_end = (qclk_q == 2'(Q_PER_CYCLE - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ap_valid_q <= 1'b0;
			ap_write_q <= 1'b0;
			ap_addr_q <= 5'h00;
			hrdata_q <= 32'h0;
		end else if (ce_i) begin
			ap_valid_q <= ap_take & ap_map;
			ap_write_q <= hwrite_i;
			ap_addr_q <= haddr_i[4:0];
			// captured at the address phase so it stands through the data phase
			if (ap_take & ~hwrite_i) hrdata_q <= ap_map ? rd_mux : 32'h0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= EID_ST_IDLE;
			insn_q <= 14'h0000;
			acc_q <= 8'h00;
			file_q <= 8'h00;
			flags_q <= 5'h18;
			ptr_top_q <= 1'b0;
			qclk_q <= 2'b00;
			cycles_left_q <= 2'b00;
			cycles_q <= 2'b00;
			busy_q <= 1'b0;
			result_q <= 8'h00;
			res_to_acc_q <= 1'b0;
			file_rd_q <= 1'b0;
			file_wr_q <= 1'b0;
		end else if (ce_i) begin
			if (wr_insn & ~busy_q) insn_q <= hwdata_i[13:0];
			if (wr_ctrl & ~busy_q) begin
				acc_q <= hwdata_i[7:0];
				ptr_top_q <= hwdata_i[8];
			end
			if (wr_flags & ~busy_q) begin
				flags_q <= hwdata_i[4:0];
				file_q <= hwdata_i[15:8];
			end
			unique case (state_q)
				EID_ST_IDLE: if (wr_ctrl & hwdata_i[31] & ~busy_q) begin
					state_q <= EID_ST_EXEC;
					busy_q <= 1'b1;
					qclk_q <= 2'b00;
					cycles_left_q <= n_cycles;
					cycles_q <= n_cycles;
					// read-modify-write: operand latched, commit at end of cycle
					file_rd_q <= file_op;
					file_wr_q <= wr_file;
					res_to_acc_q <= to_acc;
					result_q <= res;
				end
				EID_ST_EXEC: begin
					qclk_q <= qclk_q + 2'b01;
					if (quarter_end) begin
						acc_q <= acc_d;
						file_q <= file_d;
						flags_q <= flags_d;
						cycles_left_q <= cycles_left_q - 2'b01;
						state_q <= (cycles_left_q == 2'b01) ? EID_ST_IDLE : EID_ST_EXTRA;
						busy_q <= (cycles_left_q != 2'b01);
					end
				end
				EID_ST_EXTRA: begin // extra cycles run as nop
					qclk_q <= qclk_q + 2'b01;
					if (quarter_end) begin
						cycles_left_q <= cycles_left_q - 2'b01;
						if (cycles_left_q == 2'b01) begin
							state_q <= EID_ST_IDLE;
							busy_q <= 1'b0;
						end
					end
				end
				default: state_q <= EID_ST_IDLE;
			endcase
		end
	end
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign busy_o = busy_q;
	// checks
	property p_no_ext;
		@(posedge clk_i) disable iff (rst_i) $rose(busy_q) |-> cycles_q inside {2'd1, 2'd2, 2'd3};
	endproperty
	a_no_ext: assert property (p_no_ext) else $error("cycle count out of range");
	property p_quarter;
		@(posedge clk_i) disable iff (rst_i) ce_i && state_q == EID_ST_EXEC && qclk_q == 2'b00 |-> ##3 (qclk_q == 2'b11 || !ce_i);
	endproperty
	a_quarter: assert property (p_quarter) else $error("cycle not four clocks");
	property p_two;
		@(posedge clk_i) disable iff (rst_i) $rose(busy_q) && two_cyc && !extra_cyc |-> cycles_q == 2'd2;
	endproperty
	a_two: assert property (p_two) else $error("branch not two cycles");
	property p_extra;
		@(posedge clk_i) disable iff (rst_i) $rose(busy_q) && $past(extra_cyc) |-> cycles_q >= 2'd2;
	endproperty
	a_extra: assert property (p_extra) else $error("indirect penalty missing");
	property p_clrz;
		@(posedge clk_i) disable iff (rst_i) (op == EID_OP_CLEAR_ACC || op == EID_OP_CLEAR_FILE) |-> flags_d[`EID_STATUS_Z];
	endproperty
	a_clrz: assert property (p_clrz) else $error("clear did not set zero");
	property p_rot;
		@(posedge clk_i) disable iff (rst_i) (op == EID_OP_RLC || op == EID_OP_RRC) |-> flags_d[`EID_STATUS_Z] == flags_q[`EID_STATUS_Z];
	endproperty
	a_rot: assert property (p_rot) else $error("rotate touched zero");
	property p_nop;
		@(posedge clk_i) disable iff (rst_i) op == EID_OP_NOP |-> flags_d == flags_q && acc_d == acc_q && n_cycles == 2'd1;
	endproperty
	a_nop: assert property (p_nop) else $error("unknown word had effect");
	property p_wdt;
		@(posedge clk_i) disable iff (rst_i) op == EID_OP_WDTCLR |-> flags_d[`EID_STATUS_TO] && flags_d[`EID_STATUS_PD];
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear flags wrong");
	property p_dest;
		@(posedge clk_i) disable iff (rst_i) op == EID_OP_ADD_ACC_FILE && !dest |-> to_acc && !wr_file;
	endproperty
	a_dest: assert property (p_dest) else $error("destination steering wrong");
	c_branch: cover property (@(posedge clk_i) $rose(busy_q) && cycles_q == 2'd2);
	c_three: cover property (@(posedge clk_i) $rose(busy_q) && cycles_q == 2'd3);
	c_single: cover property (@(posedge clk_i) $rose(busy_q) && cycles_q == 2'd1);
endmodule : eid_decoder

// ===== eid_pkg.sv
// types for the enhanced instruction decoder
package eid_pkg;
	typedef enum logic [5:0] {
		EID_OP_NOP = 6'h00, EID_OP_ADD_ACC_FILE = 6'h01, EID_OP_ADD_ACC_FILE_CARRY = 6'h02, EID_OP_AND_ACC_FILE = 6'h03,
		EID_OP_ASR = 6'h04, EID_OP_LSL = 6'h05, EID_OP_LSR = 6'h06, EID_OP_CLEAR_FILE = 6'h07,
		EID_OP_CLEAR_ACC = 6'h08, EID_OP_COMF = 6'h09, EID_OP_DECREMENT_FILE = 6'h0A, EID_OP_INCREMENT_FILE = 6'h0B,
		EID_OP_IORWF = 6'h0C, EID_OP_MOVE_FILE = 6'h0D, EID_OP_MOVWF = 6'h0E, EID_OP_RLC = 6'h0F,
		EID_OP_RRC = 6'h10, EID_OP_SUBWF = 6'h11, EID_OP_SUB_ACC_FILE_BORROW = 6'h12, EID_OP_SWAP = 6'h13,
		EID_OP_XORWF = 6'h14, EID_OP_DECSZ = 6'h15, EID_OP_INCSZ = 6'h16, EID_OP_BCLR = 6'h17,
		EID_OP_BSET = 6'h18, EID_OP_BTSC = 6'h19, EID_OP_BTSS = 6'h1A, EID_OP_ADDLIT = 6'h1B,
		EID_OP_ANDLIT = 6'h1C, EID_OP_ORLIT = 6'h1D, EID_OP_LDBANK = 6'h1E, EID_OP_LDPCH = 6'h1F,
		EID_OP_MOVLIT = 6'h20, EID_OP_SUBLIT = 6'h21, EID_OP_XORLIT = 6'h22, EID_OP_RELBR = 6'h23,
		EID_OP_BRACC = 6'h24, EID_OP_CALL = 6'h25, EID_OP_CALLACC = 6'h26, EID_OP_DIRECT_BRANCH = 6'h27,
		EID_OP_RETIRQ = 6'h28, EID_OP_RETLIT = 6'h29, EID_OP_RETURN = 6'h2A, EID_OP_WDTCLR = 6'h2B,
		EID_OP_OPTION = 6'h2C, EID_OP_SWRESET = 6'h2D, EID_OP_SLEEP = 6'h2E, EID_OP_TRISTATE_LOAD_OP = 6'h2F,
		EID_OP_PTRADD = 6'h30, EID_OP_IRDMODE = 6'h31, EID_OP_IRDIDX = 6'h32, EID_OP_IWRMODE = 6'h33,
		EID_OP_IWRIDX = 6'h34
	} eid_op_type;
	typedef enum logic [1:0] {
		EID_ST_IDLE = 2'b00,
		EID_ST_EXEC = 2'b01,
		EID_ST_EXTRA = 2'b11
	} eid_state_type;
endpackage : eid_pkg

// ===== enhanced_insn_decoder_tb.sv
// self-checking bench for the enhanced instruction decoder
`timescale 1ns/1ps
`include "eid_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module enhanced_insn_decoder_tb import eid_pkg::*;;
	typedef struct {logic [13:0] b; logic [13:0] m; eid_op_type op;} eid_ent_type;
	eid_ent_type t[$] = '{'{14'h0700, 14'h00FF, EID_OP_ADD_ACC_FILE}, '{14'h3D00, 14'h00FF, EID_OP_ADD_ACC_FILE_CARRY},
		'{14'h0500, 14'h00FF, EID_OP_AND_ACC_FILE}, '{14'h3700, 14'h00FF, EID_OP_ASR}, '{14'h3500, 14'h00FF, EID_OP_LSL},
		'{14'h3600, 14'h00FF, EID_OP_LSR}, '{14'h0900, 14'h00FF, EID_OP_COMF}, '{14'h0300, 14'h00FF, EID_OP_DECREMENT_FILE},
		'{14'h0A00, 14'h00FF, EID_OP_INCREMENT_FILE}, '{14'h0400, 14'h00FF, EID_OP_IORWF}, '{14'h0800, 14'h00FF, EID_OP_MOVE_FILE},
		'{14'h0D00, 14'h00FF, EID_OP_RLC}, '{14'h0C00, 14'h00FF, EID_OP_RRC}, '{14'h0200, 14'h00FF, EID_OP_SUBWF},
		'{14'h3B00, 14'h00FF, EID_OP_SUB_ACC_FILE_BORROW}, '{14'h0E00, 14'h00FF, EID_OP_SWAP}, '{14'h0600, 14'h00FF, EID_OP_XORWF},
		'{14'h0B00, 14'h00FF, EID_OP_DECSZ}, '{14'h0F00, 14'h00FF, EID_OP_INCSZ}, '{14'h0180, 14'h007F, EID_OP_CLEAR_FILE},
		'{14'h0100, 14'h0003, EID_OP_CLEAR_ACC}, '{14'h0080, 14'h007F, EID_OP_MOVWF}, '{14'h1000, 14'h03FF, EID_OP_BCLR},
		'{14'h1400, 14'h03FF, EID_OP_BSET}, '{14'h1800, 14'h03FF, EID_OP_BTSC}, '{14'h1C00, 14'h03FF, EID_OP_BTSS},
		'{14'h3E00, 14'h00FF, EID_OP_ADDLIT}, '{14'h3900, 14'h00FF, EID_OP_ANDLIT}, '{14'h3800, 14'h00FF, EID_OP_ORLIT},
		'{14'h3000, 14'h00FF, EID_OP_MOVLIT}, '{14'h3C00, 14'h00FF, EID_OP_SUBLIT}, '{14'h3A00, 14'h00FF, EID_OP_XORLIT},
		'{14'h3400, 14'h00FF, EID_OP_RETLIT}, '{14'h0020, 14'h001F, EID_OP_LDBANK}, '{14'h3180, 14'h007F, EID_OP_LDPCH},
		'{14'h3200, 14'h01FF, EID_OP_RELBR}, '{14'h2000, 14'h07FF, EID_OP_CALL}, '{14'h2800, 14'h07FF, EID_OP_DIRECT_BRANCH},
		'{14'h000B, 14'h0000, EID_OP_BRACC}, '{14'h000A, 14'h0000, EID_OP_CALLACC}, '{14'h0009, 14'h0000, EID_OP_RETIRQ},
		'{14'h0008, 14'h0000, EID_OP_RETURN}, '{14'h0064, 14'h0000, EID_OP_WDTCLR}, '{14'h0063, 14'h0000, EID_OP_SLEEP},
		'{14'h0062, 14'h0000, EID_OP_OPTION}, '{14'h0001, 14'h0000, EID_OP_SWRESET}, '{14'h0065, 14'h0002, EID_OP_TRISTATE_LOAD_OP},
		'{14'h3100, 14'h007F, EID_OP_PTRADD}, '{14'h3F00, 14'h007F, EID_OP_IRDIDX}, '{14'h3F80, 14'h007F, EID_OP_IWRIDX},
		'{14'h0010, 14'h0007, EID_OP_IRDMODE}, '{14'h0018, 14'h0007, EID_OP_IWRMODE}, '{14'h0000, 14'h0000, EID_OP_NOP},
		'{14'h0004, 14'h0003, EID_OP_NOP}, '{14'h000C, 14'h0003, EID_OP_NOP}, '{14'h0070, 14'h000F, EID_OP_NOP}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic hsel, hwrite, hready, hresp, busy;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int n_errors = 0;
	int total_checks = 0;
	always #25 clk_i = ~clk_i;
	eid_decoder #(.Q_PER_CYCLE(`EID_Q_PER_CYCLE)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .busy_o(busy));
	eid_ahb_master m (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
		.htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
	task automatic finish_test();
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		logic to;
		m.xfer(wr, a, d, q, to);
		if (to) begin
			n_errors++;
			finish_test();
		end
	endtask : bus
	// each register is read twice; only the value of the second read is returned
	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, q);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask : rd
	task automatic run(input logic [13:0] w, input logic ptr, input eid_op_type op);
		logic [7:0] acc, f, k, res;
		logic [4:0] fl;
		logic [31:0] dec, st, fo;
		logic fop, hasr;
		int c, nb;
		acc = 8'($urandom);
		f = 8'($urandom);
		fl = 5'($urandom);
		k = w[7:0];
		nb = 0;
		hasr = 1'b1;
		fop = op inside {[EID_OP_ADD_ACC_FILE:EID_OP_BTSS]} && op != EID_OP_CLEAR_ACC;
		ptr = ptr & fop;
		if (op inside {EID_OP_DECSZ, EID_OP_INCSZ} && $urandom % 2) f = {{7{op == EID_OP_INCSZ}}, 1'b1};
		c = (op inside {EID_OP_CALL, EID_OP_DIRECT_BRANCH, EID_OP_RELBR, EID_OP_BRACC, EID_OP_CALLACC, EID_OP_RETIRQ,
			EID_OP_RETLIT, EID_OP_RETURN}) ? 2 : 1;
		if ((op == EID_OP_DECSZ && f == 8'h01) || (op == EID_OP_INCSZ && f == 8'hFF) ||
			(op == EID_OP_BTSC && !f[w[9:7]]) || (op == EID_OP_BTSS && f[w[9:7]])) c = 2;
		c += (ptr && w[6:1] == 6'h00);
		case (op)
			EID_OP_MOVLIT, EID_OP_RETLIT: res = k;
			EID_OP_ADDLIT: res = acc + k;
			EID_OP_SUBLIT: res = k - acc;
			EID_OP_ANDLIT: res = acc & k;
			EID_OP_ORLIT: res = acc | k;
			EID_OP_XORLIT: res = acc ^ k;
			EID_OP_ADD_ACC_FILE: res = acc + f;
			EID_OP_DECREMENT_FILE: res = f - 8'h01;
			EID_OP_INCREMENT_FILE: res = f + 8'h01;
			EID_OP_SWAP: res = {f[3:0], f[7:4]};
			EID_OP_CLEAR_FILE, EID_OP_CLEAR_ACC: res = 8'h00;
			default: hasr = 1'b0;
		endcase
		bus(1'b1, `EID_ADDR_FLAGS, {16'h0000, f, 3'h0, fl}, st);
		bus(1'b1, `EID_ADDR_CTRL, {23'h000000, ptr, acc}, st);
		bus(1'b1, `EID_ADDR_INSN, {18'h00000, w}, st);
		bus(1'b1, `EID_ADDR_CTRL, {1'b1, 22'h000000, ptr, acc}, st);
		for (int i = 0; i < 100 && !(nb > 0 && busy !== 1'b1); i++) begin
			@(posedge clk_i);
			if (busy === 1'b1) nb++;
		end
		if (nb == 0 || busy === 1'b1) begin
			n_errors++;
			finish_test();
		end
		rd(`EID_ADDR_DEC, dec);
		rd(`EID_ADDR_STAT, st);
		rd(`EID_ADDR_FLAGS, fo);
		`CHK(dec[21:16], op)
		`CHK(nb, 4 * c)
		`CHK(st[4:3], 2'(c))
		if (hasr) `CHK(dec[7:0], res)
		if (fop) `CHK(dec[13], 1'b1)
		if (op inside {[EID_OP_ADD_ACC_FILE:EID_OP_INCSZ]} && !(op inside {EID_OP_CLEAR_FILE, EID_OP_CLEAR_ACC, EID_OP_MOVWF}))
			`CHK(dec[15:14], {~w[7], w[7]})
		if (op inside {EID_OP_CLEAR_FILE, EID_OP_CLEAR_ACC}) `CHK(fo[2], 1'b1)
		if (op inside {EID_OP_RLC, EID_OP_RRC}) `CHK(fo[2], fl[2])
		if (op == EID_OP_NOP) `CHK({dec[14], fo[4:0]}, {1'b0, fl})
		if (op == EID_OP_WDTCLR) `CHK(fo[4:3], 2'b11)
		if (op == EID_OP_SLEEP) `CHK(fo[4:3], 2'b10)
	endtask : run
	initial begin
		void'($urandom(88));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK({hrdata, busy, hresp}, 34'h0)
		rd(`EID_ADDR_FLAGS, r);
		`CHK(r[4:0], 5'h18)
		// an unmapped place takes no write and reads as zero
		bus(1'b1, 32'h0000_0020, 32'hFFFF_FFFF, r);
		rd(32'h0000_0020, r);
		`CHK(r, 32'h0000_0000)
		foreach (t[i]) begin
			for (int j = 0; j < 3; j++) begin
				run(t[i].b | (14'($urandom) & t[i].m), 1'($urandom), t[i].op);
			end
		end
		run(14'h0700, 1'b1, EID_OP_ADD_ACC_FILE);
		run(14'h0781, 1'b1, EID_OP_ADD_ACC_FILE);
		run(14'h0B81, 1'b1, EID_OP_DECSZ);
		run(14'h0702, 1'b1, EID_OP_ADD_ACC_FILE);
		finish_test();
	end
endmodule : enhanced_insn_decoder_tb
